// [pkg/tcm_pkg.sv]
// Package of constants and carrier types for the channel 3/4 mode control block.
package tcm_pkg;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  MODE_CTRL_OFFS   = 8'h1C;
  localparam logic [7:0]  CH3_VALUE_OFFS   = 8'h3C;
  localparam logic [7:0]  TIMER_CTRL_OFFS  = 8'h40;
  localparam logic [7:0]  STATUS_OFFS      = 8'h44;
  localparam logic [31:0] MODE_CTRL_RESET  = 32'h0000_0000;
  localparam logic [15:0] CH3_VALUE_RESET  = 16'h0000;
  // ---------------------------------------------------------------------------
  // Field positions of the mode control register
  // ---------------------------------------------------------------------------
  localparam int CH4_FAST_BIT   = 10;
  localparam int CH4_SEL_LSB    = 8;
  localparam int CH3_CLEAR_BIT  = 7;
  localparam int CH3_MODE_LSB   = 4;
  localparam int CH3_PRELOAD_BIT = 3;
  localparam int CH3_FAST_BIT   = 2;
  localparam int CH3_SEL_LSB    = 0;
  // Timer control register fields (local copy of loose control bits).
  localparam int CH4_ENABLE_BIT = 0;
  localparam int CH3_ENABLE_BIT = 1;
  localparam int CH3_POL_BIT    = 2;
  localparam int CH3_NPOL_BIT   = 3;
  localparam int LOCK_LSB       = 4;
  localparam int TRIG_INT_BIT   = 6;
  localparam logic [1:0] LOCK_LEVEL_FULL = 2'h3;
  // ---------------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SEL_OUTPUT     = 2'h0;
  localparam logic [1:0] SEL_INPUT_OWN  = 2'h1;
  localparam logic [1:0] SEL_INPUT_PAIR = 2'h2;
  localparam logic [1:0] SEL_INPUT_TRIG = 2'h3;
  typedef enum logic [2:0] {
    MODE_FROZEN  = 3'h0,
    MODE_SET     = 3'h1,
    MODE_CLEAR   = 3'h2,
    MODE_TOGGLE  = 3'h3,
    MODE_FORCE_L = 3'h4,
    MODE_FORCE_H = 3'h5,
    MODE_PWM1    = 3'h6,
    MODE_PWM2    = 3'h7
  } tcm_mode_t;
  // Trigger-to-reference delays in timer clocks: without and with fast enable.
  localparam int TRIG_DELAY_SLOW = 5;
  localparam int TRIG_DELAY_FAST = 3;
  localparam logic [2:0] TRIG_DELAY_SLOW_C = 3'(TRIG_DELAY_SLOW - 1);
  localparam logic [2:0] TRIG_DELAY_FAST_C = 3'(TRIG_DELAY_FAST - 1);
  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } tcm_wb_req_t;
  typedef struct packed {
    logic [15:0] count;
    logic        count_down;
    logic        update_event;
    logic        trigger_edge;
    logic        ext_trigger;
  } tcm_counter_t;
endpackage

// [hw/tcm_ref_gen.sv]
// Channel 3 compare reference generator.
`timescale 1ns/1ns
`default_nettype none
module tcm_ref_gen (
  input  wire logic         i_clock,
  input  wire logic         i_resetn,
  input  wire logic [2:0]   i_mode,
  input  wire logic         i_clear_en,
  input  wire logic         i_fast_en,
  input  wire logic [15:0]  i_value,
  input  wire tcm_pkg::tcm_counter_t i_cnt,
  output logic              o_ref
);
  logic       ref_r;
  logic       ref_nxt;
  logic [2:0] mode_d_r;
  logic       cmp_d_r;
  logic       cmp_now;
  logic       match;
  logic       pwm;
  logic [2:0] trig_cnt_r;
  logic [2:0] trig_cnt_nxt;
  logic       trig_busy_r;
  logic       trig_busy_nxt;
  logic       trig_fire;

  assign o_ref = ref_r;
  assign match = (i_cnt.count == i_value);
  assign pwm   = (i_mode == tcm_pkg::MODE_PWM1) || (i_mode == tcm_pkg::MODE_PWM2);
  // PWM level for mode 1; mode 2 is its inverse.
  assign cmp_now = i_cnt.count_down ? !(i_cnt.count > i_value) : (i_cnt.count < i_value);

  // ---------------------------------------------------------------------------
  // Trigger acceleration
  // ---------------------------------------------------------------------------
  // In the PWM modes a trigger edge acts as a match after a fixed delay, shorter with fast enable.
  always_comb begin
    trig_cnt_nxt  = trig_cnt_r;
    trig_busy_nxt = trig_busy_r;
    trig_fire     = 1'b0;
    if (trig_busy_r) begin
      if (trig_cnt_r == 3'h0) begin
        trig_busy_nxt = 1'b0;
        trig_fire     = 1'b1;
      end else begin
        trig_cnt_nxt = trig_cnt_r - 3'h1;
      end
    end else if (i_cnt.trigger_edge && pwm) begin
      trig_busy_nxt = 1'b1;
      trig_cnt_nxt  = i_fast_en ? tcm_pkg::TRIG_DELAY_FAST_C - 3'h1
                                : tcm_pkg::TRIG_DELAY_SLOW_C - 3'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Reference level
  // ---------------------------------------------------------------------------
  always_comb begin
    ref_nxt = ref_r;
    case (tcm_pkg::tcm_mode_t'(i_mode))
      tcm_pkg::MODE_FROZEN:  ref_nxt = ref_r;
      tcm_pkg::MODE_SET:     if (match) ref_nxt = 1'b1;
      tcm_pkg::MODE_CLEAR:   if (match) ref_nxt = 1'b0;
      tcm_pkg::MODE_TOGGLE:  if (match) ref_nxt = !ref_r;
      tcm_pkg::MODE_FORCE_L: ref_nxt = 1'b0;
      tcm_pkg::MODE_FORCE_H: ref_nxt = 1'b1;
      tcm_pkg::MODE_PWM1, tcm_pkg::MODE_PWM2: begin
        // Compare drives the level only on an outcome change or on leaving frozen; a trigger fire also sets it.
        if ((cmp_now != cmp_d_r) || (mode_d_r == tcm_pkg::MODE_FROZEN)) begin
          ref_nxt = (i_mode == tcm_pkg::MODE_PWM1) ? cmp_now : !cmp_now;
        end
        if (trig_fire) begin
          ref_nxt = (i_mode == tcm_pkg::MODE_PWM1);
        end
      end
      default: ref_nxt = ref_r;
    endcase
    if (i_clear_en && i_cnt.ext_trigger) begin
      ref_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      ref_r       <= 1'b0;
      mode_d_r    <= 3'h0;
      cmp_d_r     <= 1'b0;
      trig_cnt_r  <= 3'h0;
      trig_busy_r <= 1'b0;
    end else begin
      ref_r       <= ref_nxt;
      mode_d_r    <= i_mode;
      cmp_d_r     <= cmp_now;
      trig_cnt_r  <= trig_cnt_nxt;
      trig_busy_r <= trig_busy_nxt;
    end
  end
endmodule
`default_nettype wire

// [hw/tcm_top.sv]
// Channel 3/4 mode control with Wishbone register access.
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module tcm_top (
  input  wire logic                  i_clock,
  input  wire logic                  i_resetn,
  input  wire tcm_pkg::tcm_wb_req_t  i_wb,
  output logic                       o_wb_ack,
  output logic [31:0]                o_wb_dat,
  input  wire tcm_pkg::tcm_counter_t i_cnt,
  input  wire logic                  i_timer_input_three,
  input  wire logic                  i_timer_input_four,
  input  wire logic                  i_internal_trigger_source,
  output logic                       o_ch3_true_output,
  output logic                       o_ch3_complement_output,
  output logic                       o_ch4_is_output,
  output logic                       o_ch4_capture_input
);
  logic [31:0] mode_r;
  logic [31:0] mode_nxt;
  logic [6:0]  tctl_r;
  logic [6:0]  tctl_nxt;
  logic [15:0] value_r;
  logic [15:0] value_nxt;
  logic [15:0] shadow_r;
  logic [15:0] shadow_nxt;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [31:0] rdat_nxt;
  logic        out_t_r;
  logic        out_c_r;
  logic        ch4_out_r;
  logic        ch4_in_r;
  logic        ch4_in_nxt;
  logic        ref_w;
  logic        req;
  logic        wr;
  logic        lock3;
  logic        preload;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Merge a write under byte enables.
  function automatic logic [31:0] tcm_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction

  assign req     = i_wb.cyc && i_wb.stb && !ack_r;
  assign wr      = req && i_wb.we;
  assign preload = mode_r[tcm_pkg::CH3_PRELOAD_BIT];
  assign lock3   = (tctl_r[tcm_pkg::LOCK_LSB +: 2] == tcm_pkg::LOCK_LEVEL_FULL)
                && (mode_r[tcm_pkg::CH3_SEL_LSB +: 2] == tcm_pkg::SEL_OUTPUT);

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [31:0] m;
    m          = tcm_merge(mode_r, i_wb.dat, i_wb.sel);
    mode_nxt   = mode_r;
    tctl_nxt   = tctl_r;
    value_nxt  = value_r;
    shadow_nxt = shadow_r;
    if (wr && (i_wb.adr == tcm_pkg::MODE_CTRL_OFFS)) begin
      // Only bits 10:0 are implemented; upper bits stay zero.
      mode_nxt[tcm_pkg::CH4_FAST_BIT] = m[tcm_pkg::CH4_FAST_BIT];
      if (!tctl_r[tcm_pkg::CH4_ENABLE_BIT]) begin
        mode_nxt[tcm_pkg::CH4_SEL_LSB +: 2] = m[tcm_pkg::CH4_SEL_LSB +: 2];
      end
      if (!lock3) begin
        mode_nxt[tcm_pkg::CH3_CLEAR_BIT]    = m[tcm_pkg::CH3_CLEAR_BIT];
        mode_nxt[tcm_pkg::CH3_MODE_LSB +: 3] = m[tcm_pkg::CH3_MODE_LSB +: 3];
        mode_nxt[tcm_pkg::CH3_PRELOAD_BIT]  = m[tcm_pkg::CH3_PRELOAD_BIT];
        mode_nxt[tcm_pkg::CH3_FAST_BIT]     = m[tcm_pkg::CH3_FAST_BIT];
      end
      if (!tctl_r[tcm_pkg::CH3_ENABLE_BIT]) begin
        mode_nxt[tcm_pkg::CH3_SEL_LSB +: 2] = m[tcm_pkg::CH3_SEL_LSB +: 2];
      end
    end
    if (wr && (i_wb.adr == tcm_pkg::TIMER_CTRL_OFFS)) begin
      tctl_nxt = m[6:0];
    end
    if (wr && (i_wb.adr == tcm_pkg::CH3_VALUE_OFFS)) begin
      shadow_nxt = m[15:0];
      if (!preload) begin
        value_nxt = m[15:0];
      end
    end
    // Update event copies the shadow only when preloading; a same-cycle write
    // still lands in the shadow and is picked up at the following update.
    if (preload && i_cnt.update_event) begin
      value_nxt = shadow_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Read path and acknowledge
  // ---------------------------------------------------------------------------
  // Read data is refreshed only by a taken request, so it stays put between
  // transfers even while the address lines wander or the status moves.
  always_comb begin
    rdat_nxt = rdat_r;
    if (req) begin
      case (i_wb.adr)
        tcm_pkg::MODE_CTRL_OFFS:  rdat_nxt = mode_r;
        tcm_pkg::CH3_VALUE_OFFS:  rdat_nxt = {16'h0000, preload ? shadow_r : value_r};
        tcm_pkg::TIMER_CTRL_OFFS: rdat_nxt = {25'h0000000, tctl_r};
        tcm_pkg::STATUS_OFFS:     rdat_nxt = {28'h0000000, ch4_in_r, ch4_out_r, out_c_r, ref_w};
        default:                  rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Channel 4 input routing
  // ---------------------------------------------------------------------------
  always_comb begin
    ch4_in_nxt = 1'b0;
    case (mode_r[tcm_pkg::CH4_SEL_LSB +: 2])
      tcm_pkg::SEL_INPUT_OWN:  ch4_in_nxt = i_timer_input_four;
      tcm_pkg::SEL_INPUT_PAIR: ch4_in_nxt = i_timer_input_three;
      tcm_pkg::SEL_INPUT_TRIG: ch4_in_nxt = tctl_r[tcm_pkg::TRIG_INT_BIT]
                                            && i_internal_trigger_source;
      default:                 ch4_in_nxt = 1'b0;
    endcase
  end

  tcm_ref_gen u_ref (
    .i_clock    (i_clock),
    .i_resetn   (i_resetn),
    .i_mode     (mode_r[tcm_pkg::CH3_MODE_LSB +: 3]),
    .i_clear_en (mode_r[tcm_pkg::CH3_CLEAR_BIT]),
    .i_fast_en  (mode_r[tcm_pkg::CH3_FAST_BIT]),
    .i_value    (value_r),
    .i_cnt      (i_cnt),
    .o_ref      (ref_w)
  );

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_r    <= tcm_pkg::MODE_CTRL_RESET;
      tctl_r    <= 7'h00;
      value_r   <= tcm_pkg::CH3_VALUE_RESET;
      shadow_r  <= tcm_pkg::CH3_VALUE_RESET;
      ack_r     <= 1'b0;
      rdat_r    <= 32'h0000_0000;
      out_t_r   <= 1'b0;
      out_c_r   <= 1'b0;
      ch4_out_r <= 1'b1;
      ch4_in_r  <= 1'b0;
    end else begin
      mode_r    <= mode_nxt;
      tctl_r    <= tctl_nxt;
      value_r   <= value_nxt;
      shadow_r  <= shadow_nxt;
      ack_r     <= req;
      rdat_r    <= rdat_nxt;
      // Polarity bit set means the output is active low.
      out_t_r   <= ref_w ^ tctl_r[tcm_pkg::CH3_POL_BIT];
      out_c_r   <= !ref_w ^ tctl_r[tcm_pkg::CH3_NPOL_BIT];
      ch4_out_r <= (mode_r[tcm_pkg::CH4_SEL_LSB +: 2] == tcm_pkg::SEL_OUTPUT);
      ch4_in_r  <= ch4_in_nxt;
    end
  end

  assign o_wb_ack                = ack_r;
  assign o_wb_dat                = rdat_r;
  assign o_ch3_true_output       = out_t_r;
  assign o_ch3_complement_output = out_c_r;
  assign o_ch4_is_output         = ch4_out_r;
  assign o_ch4_capture_input     = ch4_in_r;
endmodule
`default_nettype wire

// [verif/tcm_top_checker.sv]
// Port assertions for the channel 3/4 mode control block.
`timescale 1ns/1ns
`default_nettype none
module tcm_top_checker (
  input wire logic                 i_clock,
  input wire logic                 i_resetn,
  input wire tcm_pkg::tcm_wb_req_t i_wb,
  input wire logic                 o_wb_ack,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 o_ch4_is_output
);
  // ---------------------------------------------------------------------------
  // Bus and direction relations
  // ---------------------------------------------------------------------------
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic tk;
  logic rd;
  logic um;
  assign tk = i_wb.cyc && i_wb.stb && !o_wb_ack;
  assign rd = tk && !i_wb.we;
  assign um = !(i_wb.adr inside {tcm_pkg::MODE_CTRL_OFFS, tcm_pkg::CH3_VALUE_OFFS,
                                 tcm_pkg::TIMER_CTRL_OFFS, tcm_pkg::STATUS_OFFS});
  chk_ack_follows_req: assert property (tk |=> o_wb_ack)
    else $error("ack missing after request");
  chk_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held too long");
  chk_ack_has_cause: assert property ($rose(o_wb_ack) |-> $past(tk))
    else $error("ack without request");
  chk_read_data_holds: assert property (!$past(tk) |-> $stable(o_wb_dat))
    else $error("read data moved without request");
  chk_unmapped_zero: assert property (o_wb_ack && $past(rd && um) |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  chk_mode_upper_zero: assert property (
    o_wb_ack && $past(rd && i_wb.adr == tcm_pkg::MODE_CTRL_OFFS) |-> o_wb_dat[31:11] == 21'h0)
    else $error("mode register upper bits not zero");
  chk_status_dir_mirror: assert property (
    o_wb_ack && $past(rd && i_wb.adr == tcm_pkg::STATUS_OFFS)
    |-> o_wb_dat[2] == $past(o_ch4_is_output))
    else $error("status direction bit differs from pin");
  chk_dir_needs_write: assert property (
    $changed(o_ch4_is_output) |-> $past(o_wb_ack) || $past(o_wb_ack, 2))
    else $error("channel 4 direction changed without write");
endmodule
bind tcm_top tcm_top_checker chk (.i_clock(i_clock), .i_resetn(i_resetn), .i_wb(i_wb),
  .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat), .o_ch4_is_output(o_ch4_is_output));
`default_nettype wire

// [verif/tcm_counter_model.sv]
// Counter core model: 16-step count, wrap update pulse, trigger pass-through.
`timescale 1ns/1ns
`default_nettype none
module tcm_counter_model (
  input  wire logic             i_clock,
  input  wire logic             i_resetn,
  input  wire logic             i_down,
  input  wire logic             i_upd_en,
  input  wire logic             i_trig,
  input  wire logic             i_ext,
  output var tcm_pkg::tcm_counter_t o_cnt
);
  logic [3:0] cnt_r;
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_r <= 4'h0;
    end else begin
      cnt_r <= i_down ? cnt_r - 4'h1 : cnt_r + 4'h1;
    end
  end
  // Update fires only at the wrap, so a shadow reload lands once per period.
  always_comb begin
    o_cnt.count        = {12'h000, cnt_r};
    o_cnt.count_down   = i_down;
    o_cnt.update_event = i_upd_en && (cnt_r == (i_down ? 4'h0 : 4'hF));
    o_cnt.trigger_edge = i_trig;
    o_cnt.ext_trigger  = i_ext;
  end
endmodule
`default_nettype wire

// [verif/tcm_top_tb.sv]
// Self-checking bench for the channel 3/4 mode control block.
`timescale 1ns/1ns
`default_nettype none
module tcm_top_tb;
  // ---------------------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------------------
  localparam logic [7:0] MR = tcm_pkg::MODE_CTRL_OFFS;
  localparam logic [7:0] VR = tcm_pkg::CH3_VALUE_OFFS;
  localparam logic [7:0] TR = tcm_pkg::TIMER_CTRL_OFFS;
  localparam logic [7:0] SR = tcm_pkg::STATUS_OFFS;
  logic i_clock, i_resetn, dn, ue, tg, ex, ti3, ti4, internal_trigger_source, ack, iso, cap, p3, n3;
  logic [31:0]           dat, q;
  tcm_pkg::tcm_wb_req_t  wb;
  tcm_pkg::tcm_counter_t cnt;
  int                    miscompares, cmp_count, hp, hn, n;
  tcm_counter_model pm (.i_clock(i_clock), .i_resetn(i_resetn), .i_down(dn), .i_upd_en(ue),
    .i_trig(tg), .i_ext(ex), .o_cnt(cnt));
  tcm_top dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_wb(wb), .o_wb_ack(ack),
    .o_wb_dat(dat), .i_cnt(cnt), .i_timer_input_three(ti3), .i_timer_input_four(ti4),
    .i_internal_trigger_source(internal_trigger_source), .o_ch3_true_output(p3), .o_ch3_complement_output(n3),
    .o_ch4_is_output(iso), .o_ch4_capture_input(cap));
  task automatic print_verdict;
    $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_clock);
    wb <= {1'b1, 1'b1, w, 4'hF, a, d};
    do begin
      @(posedge i_clock);
      k++;
    end while (ack !== 1'b1 && k < 40);
    q = dat;
    wb <= '0;
    if (k >= 40) begin
      miscompares++;
      print_verdict();
    end
  endtask
  function automatic logic [31:0] mw(input logic [2:0] m, input logic p, input logic c,
                                     input logic f);
    return {24'h0, c, m, p, f, 2'h0};
  endfunction
  task automatic rf(input logic e);
    bus(1'b0, SR, 32'h0);
    chk("reference", e, q[0]);
  endtask
  task automatic hi;
    hp = 0;
    hn = 0;
    repeat (16) begin
      @(posedge i_clock);
      hp += int'(p3 === 1'b1);
      hn += int'(n3 === 1'b1);
    end
  endtask
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_ch4;
    bus(1'b0, MR, 32'h0);
    chk("mode reset", tcm_pkg::MODE_CTRL_RESET, q);
    chk("ch4 dir reset", 1'b1, iso);
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, TR, 32'h40);
      bus(1'b1, MR, {22'h0, 2'(s), 8'h00});
      {ti4, ti3, internal_trigger_source} <= 3'b100;
      repeat (4) @(posedge i_clock);
      chk("capture a", s == 1, cap);
      {ti4, ti3, internal_trigger_source} <= 3'b011;
      repeat (4) @(posedge i_clock);
      chk("capture b", s != 1, cap);
      chk("ch4 input", 1'b0, iso);
    end
    bus(1'b1, TR, 32'h41);
    bus(1'b1, MR, {22'h0, 2'h1, 8'h00});
    bus(1'b0, MR, 32'h0);
    chk("ch4 sel locked", 2'h3, q[9:8]);
    bus(1'b1, TR, 32'h0);
    repeat (4) @(posedge i_clock);
    chk("trigger gated", 1'b0, cap);
    bus(1'b1, MR, 32'h400);
    bus(1'b0, MR, 32'h0);
    chk("mode readback", 32'h400, q);
    chk("ch4 output", 1'b1, iso);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped read", 32'h0, q);
  endtask
  task automatic t_modes;
    logic [2:0] ms [8] = '{3'h5, 3'h4, 3'h1, 3'h2, 3'h5, 3'h0, 3'h4, 3'h0};
    logic [7:0] ev = 8'h35;
    logic       a;
    bus(1'b1, VR, 32'h5);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, MR, mw(ms[i], 1'b0, 1'b0, 1'b0));
      repeat (20) @(posedge i_clock);
      rf(ev[i]);
    end
    bus(1'b1, MR, mw(3'h3, 1'b0, 1'b0, 1'b0));
    repeat (20) @(posedge i_clock);
    bus(1'b0, SR, 32'h0);
    a = q[0];
    repeat (13) @(posedge i_clock);
    rf(!a);
  endtask
  task automatic t_pwm;
    int et [5] = '{5, 11, 6, 10, 11};
    int ec [5] = '{11, 5, 10, 6, 5};
    ue <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      dn <= (i == 2 || i == 3);
      bus(1'b1, TR, (i == 4) ? 32'hC : 32'h0);
      bus(1'b1, MR, mw((i % 2) ? 3'h7 : 3'h6, 1'b1, 1'b0, 1'b0));
      repeat (40) @(posedge i_clock);
      hi();
      chk("pwm true", et[i], hp);
      chk("pwm complement", ec[i], hn);
    end
    bus(1'b1, TR, 32'h0);
    ue <= 1'b0;
    bus(1'b1, VR, 32'hC);
    repeat (40) @(posedge i_clock);
    hi();
    chk("shadow held", 5, hp);
    ue <= 1'b1;
    repeat (40) @(posedge i_clock);
    hi();
    chk("shadow loaded", 12, hp);
    ue <= 1'b0;
    bus(1'b1, MR, mw(3'h6, 1'b0, 1'b0, 1'b0));
    bus(1'b1, VR, 32'h3);
    repeat (2) @(posedge i_clock);
    hi();
    chk("direct value", 3, hp);
  endtask
  task automatic t_clear_lock;
    bus(1'b1, MR, mw(3'h5, 1'b0, 1'b1, 1'b0));
    ex <= 1'b1;
    repeat (4) @(posedge i_clock);
    rf(1'b0);
    ex <= 1'b0;
    repeat (4) @(posedge i_clock);
    rf(1'b1);
    bus(1'b1, MR, mw(3'h5, 1'b0, 1'b0, 1'b0));
    ex <= 1'b1;
    repeat (4) @(posedge i_clock);
    rf(1'b1);
    ex <= 1'b0;
    bus(1'b1, TR, 32'h30);
    bus(1'b1, MR, mw(3'h4, 1'b0, 1'b0, 1'b0));
    bus(1'b0, MR, 32'h0);
    chk("mode locked", 3'h5, q[6:4]);
    bus(1'b1, TR, 32'h0);
    bus(1'b1, MR, mw(3'h4, 1'b0, 1'b0, 1'b0));
    bus(1'b0, MR, 32'h0);
    chk("mode unlocked", 3'h4, q[6:4]);
  endtask
  task automatic t_trig;
    bus(1'b1, VR, 32'h0);
    bus(1'b1, MR, mw(3'h5, 1'b0, 1'b0, 1'b0));
    bus(1'b1, MR, mw(3'h6, 1'b0, 1'b0, 1'b0));
    repeat (20) @(posedge i_clock);
    rf(1'b1);
    for (int f = 1; f >= 0; f--) begin
      bus(1'b1, MR, mw(3'h4, 1'b0, 1'b0, 1'b0));
      bus(1'b1, MR, mw(3'h0, 1'b0, 1'b0, 1'b0));
      bus(1'b1, MR, mw(3'h6, 1'b0, 1'b0, 1'(f)));
      repeat (20) @(posedge i_clock);
      rf(1'b0);
      @(posedge i_clock);
      tg <= 1'b1;
      @(posedge i_clock);
      tg <= 1'b0;
      n = 0;
      while (p3 !== 1'b1 && n < 20) begin
        @(posedge i_clock);
        #1;
        n++;
      end
      chk("trigger delay", f ? tcm_pkg::TRIG_DELAY_FAST : tcm_pkg::TRIG_DELAY_SLOW, n);
    end
  endtask
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  initial begin
    {i_resetn, dn, ue, tg, ex, ti3, ti4, internal_trigger_source} = '0;
    wb = '0;
    miscompares = 0;
    cmp_count = 0;
    repeat (12) @(posedge i_clock);
    i_resetn <= 1'b1;
    t_ch4();
    t_modes();
    t_pwm();
    t_clear_lock();
    t_trig();
    print_verdict();
  end
endmodule
`default_nettype wire
